// ---- rtl/clk_rst_mode_pkg.sv ----
// constants and types shared by the clock, reset and mode selection logic
`default_nettype none
package clk_rst_mode_pkg;
    // -------------------------------------------------------------------
    // timing counts, in core_clk cycles
    // -------------------------------------------------------------------
    localparam int unsigned CLK_DIVIDE = 2;
    localparam int unsigned RST_OUT_DELAY = 2;
    localparam int unsigned FETCH_DELAY = 7;
    localparam int unsigned STRAP_DELAY = 4;
    localparam int unsigned TEST_RESAMPLE = 5;
    localparam int unsigned MIN_RESET_CLOCKS = 5;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    // -------------------------------------------------------------------
    // values after reset
    // -------------------------------------------------------------------
    localparam logic SYSCLK_RESET = 1'b0;
    localparam logic MODE_RESET = 1'b0;

    typedef enum logic [0:0] {
        MODE_COMPATIBLE = 1'b0,
        MODE_ENHANCED = 1'b1
    } op_mode_t;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_RELEASE = 3'b001,
        ST_STRAP = 3'b010,
        ST_RUN = 3'b011,
        ST_WAIT_TEST = 3'b100
    } seq_state_t;
endpackage
`default_nettype wire

// ---- rtl/sync_2ff.sv ----
// two flip-flop synchroniser for asynchronous level inputs
`default_nettype none
module sync_2ff #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            meta_q <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/clock_reset_mode_select.sv ----
// clock divider, reset synchroniser, strap mode select and wait-for-test gate
`default_nettype none
module clock_reset_mode_select
    import clk_rst_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic reset_input_n,
    input wire logic test_busy_in,
    input wire logic test_busy_pullup,
    input wire logic wait_start,
    input wire logic int_pending,
    input wire logic int_enabled,
    input wire logic fpu_cmd_req,
    output logic system_clock_out,
    output logic reset_out,
    output logic fetch_enable,
    output clk_rst_mode_pkg::op_mode_t op_mode,
    output logic core_suspended,
    output logic int_service,
    output logic fpu_cmd_ready,
    output logic core_clear
);
    import clk_rst_mode_pkg::*;

    // -------------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------------
    logic res_sync;
    logic strap_raw;
    logic strap_sync;

    // undriven pin reads high via pull-up
    // pull-up ORed in, reads high even if the pin is driven low
    // pin only ever read, never driven here
    assign strap_raw = test_busy_in | test_busy_pullup;

    sync_2ff #(
        .WIDTH(2),
        .INIT(2'b00)
    ) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in({reset_input_n, strap_raw}),
        .sync_out({res_sync, strap_sync})
    );

    // -------------------------------------------------------------------
    // clock divider
    // -------------------------------------------------------------------
    logic sysclk_q;

    // divide by two, equal halves, runs through reset_input_n reset, held low while rst_b is low
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sysclk_q <= SYSCLK_RESET;
        end else begin
            sysclk_q <= ~sysclk_q;
        end
    end
    assign system_clock_out = sysclk_q;

    // -------------------------------------------------------------------
    // reset sequencing and strap sampling
    // -------------------------------------------------------------------
    seq_state_t state_q;
    logic [3:0] cnt_q;
    logic strap_first_q;
    op_mode_t mode_q;
    logic rst_out_q;
    logic [3:0] rst_cnt_q;

    always_ff @(posedge core_clk) begin
        if (!rst_b || !res_sync) begin
            rst_out_q <= 1'b1;
            rst_cnt_q <= CNT_ZERO;
        end else if (rst_cnt_q < 4'(RST_OUT_DELAY - 1)) begin
            rst_cnt_q <= rst_cnt_q + 4'h1;
        end else begin
            rst_out_q <= 1'b0;
        end
    end
    assign reset_out = rst_out_q;

    // dormant in reset, fetch delay, mode strap
    always_ff @(posedge core_clk) begin
        if (!rst_b || !res_sync) begin
            state_q <= ST_RESET;
            cnt_q <= CNT_ZERO;
        end else begin
            unique case (state_q)
                ST_RESET: begin
                    state_q <= ST_RELEASE;
                    cnt_q <= 4'h1;
                end
                ST_RELEASE: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(STRAP_DELAY)) begin
                        state_q <= ST_STRAP;
                    end
                end
                ST_STRAP: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(FETCH_DELAY - 1)) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (wait_start && mode_q == MODE_COMPATIBLE && strap_sync) begin
                        state_q <= ST_WAIT_TEST;
                        cnt_q <= CNT_ZERO;
                    end
                end
                ST_WAIT_TEST: begin
                    if (cnt_q == 4'(TEST_RESAMPLE - 1)) begin
                        cnt_q <= CNT_ZERO;
                        if (!strap_sync) begin
                            state_q <= ST_RUN;
                        end
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= ST_RESET;
                end
            endcase
        end
    end

    // first sample at release, reset output high there
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            strap_first_q <= 1'b0;
        end else if (state_q == ST_RESET) begin
            strap_first_q <= strap_sync;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b || !res_sync) begin
            mode_q <= op_mode_t'(MODE_RESET);
        end else if (state_q == ST_RELEASE && cnt_q == 4'(STRAP_DELAY)) begin
            mode_q <= (strap_first_q && !strap_sync) ? MODE_ENHANCED : MODE_COMPATIBLE;
        end
    end
    assign op_mode = mode_q;

    // -------------------------------------------------------------------
    // outputs to the core
    // -------------------------------------------------------------------
    // clear and hold core while reset active
    assign core_clear = (state_q == ST_RESET);
    assign fetch_enable = (state_q == ST_RUN);
    assign core_suspended = (state_q == ST_WAIT_TEST);
    assign int_service = core_suspended && int_enabled && int_pending;
    assign fpu_cmd_ready = (mode_q == MODE_ENHANCED) && fpu_cmd_req && !strap_sync
        && (state_q == ST_RUN);

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    logic [3:0] low_cnt_q;
    always_ff @(posedge core_clk) begin
        if (!rst_b || res_sync) begin
            low_cnt_q <= CNT_ZERO;
        end else if (low_cnt_q != 4'hf) begin
            low_cnt_q <= low_cnt_q + 4'h1;
        end
    end

    sequence s_release;
        !core_clear ##0 $past(core_clear);
    endsequence

    a_clock_toggle: assert property (@(posedge core_clk) disable iff (!rst_b)
        $past(rst_b) |-> system_clock_out != $past(system_clock_out))
        else $error("system clock did not toggle");
    a_duty_half: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(system_clock_out) |=> $fell(system_clock_out) ##1 $rose(system_clock_out))
        else $error("system clock duty not half");
    a_toggle_in_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
        !res_sync |=> system_clock_out != $past(system_clock_out))
        else $error("system clock stopped in reset");
    a_reset_dormant: assert property (@(posedge core_clk) disable iff (!rst_b)
        !res_sync |=> core_clear && !fetch_enable && !core_suspended)
        else $error("core active during reset");
    a_sync_delay: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(reset_input_n) |-> !core_clear ##3 core_clear)
        else $error("reset not taken through synchroniser");
    a_fetch_delay: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_release |-> !fetch_enable [*6] ##1 fetch_enable)
        else $error("fetch start delay wrong");
    a_enh_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_release ##0 strap_first_q ##3 !strap_sync |=> op_mode == MODE_ENHANCED)
        else $error("enhanced mode not selected");
    a_compat_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_release ##0 !strap_first_q |-> ##5 op_mode == MODE_COMPATIBLE)
        else $error("compatible mode not selected");
    a_strap_pull: assert property (@(posedge core_clk) disable iff (!rst_b)
        test_busy_pullup |-> ##2 strap_sync)
        else $error("pull-up not seen");
    a_wait_enter: assert property (@(posedge core_clk) disable iff (!rst_b || !res_sync)
        fetch_enable && wait_start && op_mode == MODE_COMPATIBLE && strap_sync
        |=> core_suspended)
        else $error("wait did not suspend");
    a_wait_period: assert property (@(posedge core_clk) disable iff (!rst_b || !res_sync)
        $rose(core_suspended) |-> core_suspended [*5])
        else $error("test resampled too early");
    a_int_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_suspended && int_enabled && int_pending |-> int_service)
        else $error("interrupt not serviced while waiting");
    a_fpu_busy: assert property (@(posedge core_clk) disable iff (!rst_b)
        fpu_cmd_ready |-> op_mode == MODE_ENHANCED && !strap_sync)
        else $error("coprocessor command while busy");
    a_rst_out: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(res_sync) |-> reset_out ##1 reset_out ##1 !reset_out)
        else $error("reset output release timing wrong");
    a_mode_hold: assert property (@(posedge core_clk) disable iff (!rst_b || !res_sync)
        fetch_enable && $past(fetch_enable) |-> $stable(op_mode))
        else $error("mode changed outside reset");
    a_reset_len: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(res_sync) |-> $past(low_cnt_q) >= 4'(MIN_RESET_CLOCKS))
        else $error("reset input held too briefly");

    // -------------------------------------------------------------------
    // further checks on outputs and the first strap sample
    // -------------------------------------------------------------------
    a_clear_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_clear |-> !fetch_enable && !core_suspended)
        else $error("core not quiet while cleared");
    a_clear_no_int: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_clear |-> !int_service && !fpu_cmd_ready)
        else $error("service or command while cleared");
    a_reset_out_hi: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_clear |-> reset_out)
        else $error("reset output low while cleared");
    a_release_order: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(core_clear) |-> reset_out ##1 !reset_out)
        else $error("reset output released out of order");
    a_sync_release: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(reset_input_n) |-> core_clear [*3] ##1 !core_clear)
        else $error("release not taken through synchroniser");
    a_enh_no_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
        op_mode == MODE_ENHANCED |-> !core_suspended)
        else $error("suspended in enhanced mode");
    a_compat_no_cmd: assert property (@(posedge core_clk) disable iff (!rst_b)
        op_mode == MODE_COMPATIBLE |-> !fpu_cmd_ready)
        else $error("coprocessor command in compatible mode");
    a_cmd_running: assert property (@(posedge core_clk) disable iff (!rst_b)
        fpu_cmd_ready |-> fetch_enable)
        else $error("coprocessor command while not running");
    a_busy_blocks: assert property (@(posedge core_clk) disable iff (!rst_b)
        fpu_cmd_req && strap_sync |-> !fpu_cmd_ready)
        else $error("command accepted while busy");
    a_int_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
        !core_suspended |-> !int_service)
        else $error("interrupt service outside wait");
    a_suspend_nofetch: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_suspended |-> !fetch_enable)
        else $error("fetch while suspended");
    a_wait_refused: assert property (@(posedge core_clk) disable iff (!rst_b)
        fetch_enable && wait_start && !strap_sync |=> !core_suspended)
        else $error("suspended with test pin low");
    a_wait_resume: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_suspended && !strap_sync |-> ##[1:5] !core_suspended)
        else $error("no resume after test pin low");
    a_strap_first: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_clear |=> strap_first_q == $past(strap_sync))
        else $error("first strap sample not taken");
    a_mode_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_clear && $past(core_clear) |-> op_mode == MODE_COMPATIBLE)
        else $error("mode not cleared in reset");
    a_run_stays: assert property (@(posedge core_clk) disable iff (!rst_b)
        fetch_enable && !wait_start |=> fetch_enable || core_clear)
        else $error("fetch dropped without cause");
endmodule
`default_nettype wire

// ---- verification/strap_partner.sv ----
// pin-side model: external reset network, strap driver and coprocessor busy
`default_nettype none
module strap_partner (
    input wire logic reset_out,
    input wire logic hold_reset,
    input wire logic [1:0] pin_mode,
    input wire logic pin_level,
    output logic reset_input_n,
    output logic test_busy_in,
    output logic test_busy_pullup
);
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------------------------------
    // reset network
    // -------------------------------------------------------------------
    // reset drive: the bench sets the hold length
    assign reset_input_n = !hold_reset;
    // -------------------------------------------------------------------
    // shared pin: 0 floats, 1 strap or busy level, 2 tied to reset output
    // -------------------------------------------------------------------
    // pin drivers and pull-up
    assign test_busy_pullup = (pin_mode == 2'h0);
    assign test_busy_in = (pin_mode == 2'h0) ? 1'b1 :
                          (pin_mode == 2'h2) ? reset_out : pin_level;
endmodule
`default_nettype wire

// ---- verification/clock_reset_mode_select_tb.sv ----
// self-checking bench of clock, reset, strap mode and wait-for-test logic
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module clock_reset_mode_select_tb;
    import clk_rst_mode_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst_b, reset_input_n, test_busy_in, test_busy_pullup;
    logic wait_start, int_pending, int_enabled, fpu_cmd_req;
    logic system_clock_out, reset_out, fetch_enable, core_suspended;
    logic int_service, fpu_cmd_ready, core_clear, hold_reset, pin_level;
    logic [1:0] pin_mode;
    op_mode_t op_mode;
    int fail_count = 0;
    int checks_done = 0;
    clock_reset_mode_select dut_u (.core_clk(core_clk), .rst_b(rst_b),
        .reset_input_n(reset_input_n), .test_busy_in(test_busy_in),
        .test_busy_pullup(test_busy_pullup), .wait_start(wait_start),
        .int_pending(int_pending), .int_enabled(int_enabled), .fpu_cmd_req(fpu_cmd_req),
        .system_clock_out(system_clock_out), .reset_out(reset_out),
        .fetch_enable(fetch_enable), .op_mode(op_mode), .core_suspended(core_suspended),
        .int_service(int_service), .fpu_cmd_ready(fpu_cmd_ready), .core_clear(core_clear));
    strap_partner partner_u (.reset_out(reset_out), .hold_reset(hold_reset),
        .pin_mode(pin_mode), .pin_level(pin_level), .reset_input_n(reset_input_n),
        .test_busy_in(test_busy_in), .test_busy_pullup(test_busy_pullup));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
        end
    endtask
    task automatic clk_check(input int n);
        logic prev;
        repeat (n) begin
            prev = system_clock_out;
            tick(1);
            `CHK(system_clock_out, ~prev)
        end
    endtask
    task automatic do_reset(input logic [1:0] m, input logic l0, input logic l1,
                            input op_mode_t exp);
        int t_clr;
        int t_rst;
        int t_fet;
        t_clr = 0;
        t_rst = 0;
        t_fet = 0;
        pin_mode = m;
        pin_level = l0;
        hold_reset = 1'b1;
        clk_check(6);
        `CHK({core_clear, reset_out, fetch_enable, core_suspended}, 4'hc)
        hold_reset = 1'b0;
        for (int n = 1; n <= 14; n++) begin
            tick(1);
            if (n == 2) pin_level = l1;
            if (t_clr == 0 && core_clear === 1'b0) t_clr = n;
            if (t_rst == 0 && reset_out === 1'b0) t_rst = n;
            if (t_fet == 0 && fetch_enable === 1'b1) t_fet = n;
        end
        `CHK(t_clr, 3)
        `CHK(t_rst, 2 + RST_OUT_DELAY)
        `CHK(t_fet, 2 + FETCH_DELAY)
        `CHK(op_mode, exp)
        pin_mode = 2'h1;
        pin_level = ~l1;
        clk_check(3);
        `CHK(op_mode, exp)
        $display("reset test mode %0h done", exp);
    endtask
    task automatic pulse_wait();
        wait_start = 1'b1;
        tick(1);
        wait_start = 1'b0;
        tick(1);
    endtask
    task automatic wait_test();
        int t;
        t = 0;
        pin_mode = 2'h1;
        pin_level = 1'b1;
        int_pending = 1'b1;
        tick(3);
        pulse_wait();
        `CHK(core_suspended, 1'b1)
        for (int n = 0; n < 12; n++) begin
            int_enabled = (n >= 6);
            tick(1);
            `CHK(core_suspended, 1'b1)
            `CHK(int_service, int_enabled)
        end
        pin_level = 1'b0;
        for (int n = 1; n <= 12; n++) begin
            tick(1);
            if (t == 0 && core_suspended === 1'b0) t = n;
        end
        `CHK(t > 0 && t <= 3 + TEST_RESAMPLE, 1'b1)
        pulse_wait();
        tick(2);
        `CHK(core_suspended, 1'b0)
        pin_level = 1'b1;
        tick(3);
        pulse_wait();
        `CHK(core_suspended, 1'b1)
        $display("wait test done");
    endtask
    task automatic fpu_test();
        pin_level = 1'b1;
        fpu_cmd_req = 1'b1;
        tick(4);
        `CHK(fpu_cmd_ready, 1'b0)
        pulse_wait();
        tick(2);
        // no wait gate in enhanced mode
        `CHK(core_suspended, 1'b0)
        pin_level = 1'b0;
        tick(4);
        `CHK(fpu_cmd_ready, 1'b1)
        fpu_cmd_req = 1'b0;
        tick(1);
        `CHK(fpu_cmd_ready, 1'b0)
        $display("coprocessor test done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #(100 * 3000);
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        rst_b = 1'b0;
        hold_reset = 1'b1;
        pin_mode = 2'h0;
        pin_level = 1'b0;
        wait_start = 1'b0;
        int_pending = 1'b0;
        int_enabled = 1'b0;
        fpu_cmd_req = 1'b0;
        tick(4);
        rst_b = 1'b1;
        do_reset(2'h1, 1'b1, 1'b1, MODE_COMPATIBLE);
        wait_test();
        do_reset(2'h1, 1'b1, 1'b0, MODE_ENHANCED);
        fpu_test();
        do_reset(2'h1, 1'b0, 1'b0, MODE_COMPATIBLE);
        do_reset(2'h1, 1'b0, 1'b1, MODE_COMPATIBLE);
        do_reset(2'h0, 1'b0, 1'b0, MODE_COMPATIBLE);
        do_reset(2'h2, 1'b0, 1'b0, MODE_ENHANCED);
        tally_and_finish();
    end
endmodule
`default_nettype wire
